// ---- rtl/adclp_ctrl.sv ----
`default_nettype none
// Overview of operation
// R1: Temperature sensor feeds one analog channel
// R2: Wait mode lets a running conversion finish
// R3: In wait, only hardware or continuous starts; the code also accepts a calibration start in wait
// R4: Wait keeps all conversion clock sources usable
// R5: Plain conversion sets flag, interrupt if enabled
// R6: Averaging flags only after all conversions
// R7: Compare flags only conversions meeting condition
// R8: Wait: failed single compare idles, no wake
// R9: Stop without async clock aborts conversion
// R10: Normal stop keeps all registers unchanged
// R11: After stop abort, only new trigger restarts
// R12: Async clock keeps converting through stop
// R13: Stop: result holds first completed conversion
// R14: Stop: failed single compare idles, no wake
// R15: Low-power stop disables the block
// R16: Low-power stop exit shows reset values
// R17: Config one register field layout
// R18: Trigger/compare register layout
// R19: Status/channel register layout
// R20: Software initialises in documented order
// R21: Interrupt whenever flag set and enabled
// R22: Active flag tracks conversion or calibration
// R23: Channel write aborts, restarts unless hardware
module adclp_ctrl (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        hw_trigger,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        lp_stop_mode,
  input  wire logic        alt_clock_tick,
  input  wire logic        async_clock_tick,
  input  wire logic        cmp_in,
  output logic      [11:0] dac_code,
  output logic             sample_hold,
  output logic      [4:0]  mux_channel,
  output logic             temp_sensor_en,
  output logic             conv_irq
);
  adclp_sar_if sar ();
  logic        clr;

  adclp_sar u_sar (
    .clk         (clk),
    .rstn        (!clr),  // Low-power stop clears the engine too [R15]
    .bus         (sar.eng),
    .cmp_in      (cmp_in),
    .dac_code    (dac_code),
    .sample_hold (sample_hold)
  );

  adclp_pkg::adclp_state_e state_reg;
  logic [7:0]  conversion_config_one_reg;
  logic [7:0]  trig_reg;
  logic        complete_irq_enable_reg;
  logic [4:0]  chan_reg;
  logic        conversion_complete_flag_reg;
  logic [3:0]  avg_reg;
  logic        cal_reg;
  logic        calf_reg;
  logic [15:0] cv1_reg;
  logic [15:0] cv2_reg;
  logic [15:0] res_reg;
  logic [15:0] rdata_reg;
  logic        stop_q_reg;
  logic        held_reg;
  logic        half_reg;
  logic [2:0]  div_reg;
  logic [16:0] acc_reg;
  logic [5:0]  avg_cnt_reg;
  logic [4:0]  mux_reg;
  logic        temp_reg;

  logic        cal_active;
  logic        wr_ok;
  logic        wr_chan;
  logic        wr_avg;
  logic        async_sel;
  logic        hw_sel;
  logic        stop_rise;
  logic        clocks_run;
  logic        src_tick;
  logic [2:0]  div_limit;
  logic        stop_abort;
  logic        cal_abort;
  logic        sw_start;
  logic        hw_start;
  logic        cal_start;
  logic        cal_refused;
  logic        conv_done;
  logic [16:0] sum_next;
  logic [5:0]  avg_target;
  logic        avg_last;
  logic [11:0] final_val;
  logic        cmp_ok;
  logic        cont_restart;
  logic        run_start;
  logic        conversion_complete_flag_set;
  logic        conversion_complete_flag_clr;

  // Low-power stop acts as a module reset while asserted
  assign clr        = !rstn || lp_stop_mode;  // [R15] [R16]
  assign cal_active = (state_reg == adclp_pkg::ST_CAL);
  // Registers are locked while calibration runs
  assign wr_ok      = wr && !cal_active;
  assign wr_chan    = wr_ok && (addr == adclp_pkg::OFF_CHAN);
  assign wr_avg     = wr_ok && (addr == adclp_pkg::OFF_AVG);
  assign async_sel  = (conversion_config_one_reg[adclp_pkg::CFG_CLK_LO +: 2]
                       == adclp_pkg::CLK_ASYNC);
  assign hw_sel     = trig_reg[adclp_pkg::TRG_SEL];
  assign stop_rise  = stop_mode && !stop_q_reg;

  // Conversion clock: every source runs in wait; in stop only async
  assign clocks_run = !stop_mode || async_sel;  // [R4] [R12]
  always_comb begin
    unique case (conversion_config_one_reg[adclp_pkg::CFG_CLK_LO +: 2])
      adclp_pkg::CLK_BUS:  src_tick = 1'b1;
      adclp_pkg::CLK_HALF: src_tick = half_reg;
      adclp_pkg::CLK_ALT:  src_tick = alt_clock_tick;
      default:             src_tick = async_clock_tick;
    endcase
  end

  always_comb begin
    unique case (conversion_config_one_reg[adclp_pkg::CFG_DIV_LO +: 2])
      2'h0:    div_limit = 3'h0;
      2'h1:    div_limit = 3'h1;
      2'h2:    div_limit = 3'h3;
      default: div_limit = 3'h7;
    endcase
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      half_reg <= 1'b0;
      div_reg  <= 3'h0;
    end else begin
      half_reg <= !half_reg;
      if (src_tick && clocks_run) begin
        div_reg <= (div_reg >= div_limit) ? 3'h0 : div_reg + 3'h1;
      end
    end
  end

  assign sar.tick = src_tick && clocks_run && (div_reg >= div_limit);
  assign sar.mode = conversion_config_one_reg[adclp_pkg::CFG_MODE_LO +: 2];
  assign sar.long_sample = conversion_config_one_reg[adclp_pkg::CFG_LSMP];

  // Start and abort sources
  assign stop_abort  = stop_rise && !async_sel;  // [R9]
  assign cal_abort   = cal_active && (wr || stop_rise);
  // Channel-write starts need a running core, so none arise in wait or stop
  assign sw_start    = wr_chan && !hw_sel
                       && !wait_mode && !stop_mode;  // [R3] [R23]
  assign hw_start    = hw_trigger && hw_sel && clocks_run
                       && (state_reg == adclp_pkg::ST_IDLE)
                       && !stop_abort;  // [R3] [R11] [R12]
  assign cal_start   = wr_avg && wdata[adclp_pkg::AVG_CAL] && !hw_sel
                       && (state_reg == adclp_pkg::ST_IDLE);
  assign cal_refused = wr_avg && wdata[adclp_pkg::AVG_CAL] && hw_sel;
  assign conv_done   = (state_reg == adclp_pkg::ST_RUN) && sar.done
                       && !wr_chan && !stop_abort;  // [R2]

  // Averaging accumulates until the selected count is reached
  assign sum_next   = acc_reg + {5'h00, sar.result};
  assign avg_target = 6'h04 << avg_reg[1:0];
  assign avg_last   = !avg_reg[adclp_pkg::AVG_EN]
                      || (avg_cnt_reg + 6'h01 == avg_target);  // [R6]
  always_comb begin
    if (avg_reg[adclp_pkg::AVG_EN]) begin
      final_val = 12'(sum_next >> (5'd2 + {3'h0, avg_reg[1:0]}));
    end else begin
      final_val = sar.result;
    end
  end

  // Compare against one or two thresholds, the averaged value included
  always_comb begin
    logic ge1;
    logic le2;
    ge1 = ({4'h0, final_val} >= cv1_reg);
    le2 = ({4'h0, final_val} <= cv2_reg);
    if (!trig_reg[adclp_pkg::TRG_CMPE]) begin
      cmp_ok = 1'b1;
    end else if (!trig_reg[adclp_pkg::TRG_CMPR]) begin
      cmp_ok = trig_reg[adclp_pkg::TRG_CMPGT] ? ge1 : !ge1;
    end else if (cv1_reg <= cv2_reg) begin
      cmp_ok = trig_reg[adclp_pkg::TRG_CMPGT] ? (ge1 && le2)
                                              : (!ge1 || !le2);
    end else begin
      cmp_ok = trig_reg[adclp_pkg::TRG_CMPGT] ? (ge1 || le2)
                                              : (!ge1 && !le2);
    end
  end  // [R7]

  assign cont_restart = conv_done && avg_last
                        && avg_reg[adclp_pkg::AVG_CONT];
  assign run_start    = sw_start || hw_start || cont_restart
                        || (conv_done && !avg_last);

  // Engine control; a fresh start overrides a simultaneous abort
  assign sar.start = run_start || cal_start;
  assign sar.abort = !sar.start
                     && (wr_chan || stop_abort || cal_abort);

  always_ff @(posedge clk) begin
    if (clr) begin
      state_reg <= adclp_pkg::ST_IDLE;
    end else if (cal_start) begin
      state_reg <= adclp_pkg::ST_CAL;
    end else if (run_start) begin
      state_reg <= adclp_pkg::ST_RUN;
    end else if (wr_chan || stop_abort || cal_abort) begin
      state_reg <= adclp_pkg::ST_IDLE;  // [R9] [R11] [R23]
    end else if (cal_active && sar.done) begin
      state_reg <= adclp_pkg::ST_IDLE;
    end else if (conv_done) begin
      // Single conversion ends here, flagged or not
      state_reg <= adclp_pkg::ST_IDLE;  // [R8] [R14]
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      acc_reg     <= 17'h00000;
      avg_cnt_reg <= 6'h00;
    end else if (sw_start || hw_start || avg_last && conv_done) begin
      acc_reg     <= 17'h00000;
      avg_cnt_reg <= 6'h00;
    end else if (conv_done) begin
      acc_reg     <= sum_next;
      avg_cnt_reg <= avg_cnt_reg + 6'h01;
    end
  end

  // Flag events; set beats a same-cycle clear
  assign conversion_complete_flag_set = (conv_done && avg_last && cmp_ok)
                    || (cal_active && sar.done && !cal_abort);  // [R5]
  assign conversion_complete_flag_clr = wr_chan
                    || (rd && addr == adclp_pkg::OFF_RES);

  always_ff @(posedge clk) begin
    if (clr) begin
      conversion_complete_flag_reg <= 1'b0;
    end else if (conversion_complete_flag_set) begin
      conversion_complete_flag_reg <= 1'b1;  // [R5] [R6] [R7]
    end else if (conversion_complete_flag_clr) begin
      conversion_complete_flag_reg <= 1'b0;
    end
  end

  // In stop with plain conversions, the first result is kept
  always_ff @(posedge clk) begin
    if (clr) begin
      res_reg  <= adclp_pkg::RES_RST;
      held_reg <= 1'b0;
    end else begin
      if (conv_done && avg_last && cmp_ok && !held_reg) begin
        res_reg <= {4'h0, final_val};  // [R7]
      end
      if (!stop_mode) begin
        held_reg <= 1'b0;
      end else if (conv_done && !trig_reg[adclp_pkg::TRG_CMPE]
                   && !avg_reg[adclp_pkg::AVG_EN]) begin
        held_reg <= 1'b1;  // [R13]
      end
    end
  end

  // Plain registers; stop entry and exit leave them alone
  always_ff @(posedge clk) begin
    if (clr) begin
      conversion_config_one_reg <= adclp_pkg::CONVERSION_CONFIG_ONE_RST;
      trig_reg <= adclp_pkg::TRIG_RST;
      complete_irq_enable_reg <= 1'b0;
      chan_reg <= adclp_pkg::CHAN_RST;
      avg_reg  <= adclp_pkg::AVG_RST;
      cv1_reg  <= adclp_pkg::CV_RST;
      cv2_reg  <= adclp_pkg::CV_RST;
    end else if (wr_ok) begin  // [R10]
      unique case (addr)
        adclp_pkg::OFF_CONVERSION_CONFIG_ONE: conversion_config_one_reg <= wdata[7:0];  // [R17]
        adclp_pkg::OFF_TRIG:
          trig_reg <= wdata[7:0] & adclp_pkg::TRG_WMASK;  // [R18]
        adclp_pkg::OFF_CHAN: begin
          complete_irq_enable_reg <= wdata[adclp_pkg::CH_COMPLETE_IRQ_ENABLE];  // [R19]
          chan_reg <= wdata[4:0];
        end
        adclp_pkg::OFF_AVG: avg_reg <= wdata[3:0];
        adclp_pkg::OFF_CV1: cv1_reg <= wdata;
        adclp_pkg::OFF_CV2: cv2_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Calibration status; a refused or aborted run leaves the fail flag
  always_ff @(posedge clk) begin
    if (clr) begin
      cal_reg  <= 1'b0;
      calf_reg <= 1'b0;
    end else if (cal_refused || cal_abort) begin
      cal_reg  <= 1'b0;
      calf_reg <= 1'b1;
    end else if (cal_start) begin
      cal_reg  <= 1'b1;
      calf_reg <= 1'b0;
    end else if (cal_active && sar.done) begin
      cal_reg  <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      stop_q_reg <= 1'b0;
    end else begin
      stop_q_reg <= stop_mode;
    end
  end

  // Analog mux follows the channel field
  always_ff @(posedge clk) begin
    if (clr) begin
      mux_reg  <= adclp_pkg::CHAN_RST;
      temp_reg <= 1'b0;
    end else begin
      mux_reg  <= chan_reg;
      temp_reg <= (chan_reg == adclp_pkg::TEMP_CHANNEL);  // [R1]
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (clr || !rd) begin
      rdata_reg <= 16'h0000;
    end else begin
      unique case (addr)
        adclp_pkg::OFF_CONVERSION_CONFIG_ONE: rdata_reg <= {8'h00, conversion_config_one_reg};
        adclp_pkg::OFF_TRIG:
          rdata_reg <= {8'h00, state_reg != adclp_pkg::ST_IDLE,
                        trig_reg[6:0]};  // [R22]
        adclp_pkg::OFF_CHAN:
          rdata_reg <= {8'h00, conversion_complete_flag_reg, complete_irq_enable_reg, 1'b0, chan_reg};
        adclp_pkg::OFF_AVG:
          rdata_reg <= {8'h00, cal_reg, calf_reg, 2'h0, avg_reg};
        adclp_pkg::OFF_CV1:  rdata_reg <= cv1_reg;
        adclp_pkg::OFF_CV2:  rdata_reg <= cv2_reg;
        adclp_pkg::OFF_RES:  rdata_reg <= res_reg;
        default:             rdata_reg <= 16'h0000;
      endcase
    end
  end

  assign rdata          = rdata_reg;
  assign mux_channel    = mux_reg;
  assign temp_sensor_en = temp_reg;
  assign conv_irq       = conversion_complete_flag_reg && complete_irq_enable_reg;  // [R21] [R5]
endmodule
`default_nettype wire

// ---- rtl/adclp_pkg.sv ----
`default_nettype none
package adclp_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned RES_W  = 12;

  // Register indices on the plain register port
  localparam logic [3:0] OFF_CONVERSION_CONFIG_ONE = 4'h0;
  localparam logic [3:0] OFF_TRIG = 4'h1;
  localparam logic [3:0] OFF_CHAN = 4'h2;
  localparam logic [3:0] OFF_AVG  = 4'h3;
  localparam logic [3:0] OFF_CV1  = 4'h4;
  localparam logic [3:0] OFF_CV2  = 4'h5;
  localparam logic [3:0] OFF_RES  = 4'h6;

  // conversion_config_one fields
  localparam int unsigned CFG_LPC    = 7;
  localparam int unsigned CFG_DIV_LO = 5;
  localparam int unsigned CFG_LSMP   = 4;
  localparam int unsigned CFG_MODE_LO = 2;
  localparam int unsigned CFG_CLK_LO = 0;

  // trigger_compare_control fields
  localparam int unsigned TRG_ACT   = 7;
  localparam int unsigned TRG_SEL   = 6;
  localparam int unsigned TRG_CMPE  = 5;
  localparam int unsigned TRG_CMPGT = 4;
  localparam int unsigned TRG_CMPR  = 3;
  localparam logic [7:0]  TRG_WMASK = 8'h7b;

  // channel_status_control_a fields
  localparam int unsigned CH_CONVERSION_COMPLETE_FLAG = 7;
  localparam int unsigned CH_COMPLETE_IRQ_ENABLE = 6;

  // averaging_calib_control fields
  localparam int unsigned AVG_CAL  = 7;
  localparam int unsigned AVG_CALF = 6;
  localparam int unsigned AVG_CONT = 3;
  localparam int unsigned AVG_EN   = 2;

  // Reset values
  localparam logic [7:0]  CONVERSION_CONFIG_ONE_RST = 8'h00;
  localparam logic [7:0]  TRIG_RST = 8'h00;
  localparam logic [4:0]  CHAN_RST = 5'h1f;
  localparam logic [3:0]  AVG_RST  = 4'h0;
  localparam logic [15:0] CV_RST   = 16'h0000;
  localparam logic [15:0] RES_RST  = 16'h0000;

  // Input clock codes
  localparam logic [1:0] CLK_BUS   = 2'h0;
  localparam logic [1:0] CLK_HALF  = 2'h1;
  localparam logic [1:0] CLK_ALT   = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;

  // Resolution codes
  localparam logic [1:0] MODE_8  = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;

  // Channel wired to the on-chip temperature sensor
  localparam logic [4:0] TEMP_CHANNEL = 5'h1a;

  // Sample window in conversion clock ticks
  localparam logic [5:0] SAMPLE_SHORT = 6'h04;
  localparam logic [5:0] SAMPLE_LONG  = 6'h18;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_CAL  = 3'b100
  } adclp_state_e;

  typedef enum logic [2:0] {
    E_IDLE   = 3'b001,
    E_SAMPLE = 3'b010,
    E_SAR    = 3'b100
  } adclp_eng_e;
endpackage
`default_nettype wire

// ---- rtl/adclp_sar_if.sv ----
`default_nettype none
interface adclp_sar_if;
  logic        start;
  logic        abort;
  logic        tick;
  logic [1:0]  mode;
  logic        long_sample;
  logic        busy;
  logic        done;
  logic [11:0] result;

  modport ctl (output start, abort, tick, mode, long_sample,
               input busy, done, result);
  modport eng (input start, abort, tick, mode, long_sample,
               output busy, done, result);
endinterface
`default_nettype wire

// ---- rtl/adclp_sar.sv ----
`default_nettype none
module adclp_sar (
  input  wire logic     clk,
  input  wire logic     rstn,
  adclp_sar_if.eng      bus,
  input  wire logic     cmp_in,
  output logic [11:0]   dac_code,
  output logic          sample_hold
);
  adclp_pkg::adclp_eng_e state_reg;
  logic [5:0]  cnt_reg;
  logic [3:0]  bit_reg;
  logic [11:0] code_reg;
  logic        done_reg;
  logic [11:0] res_reg;
  logic [5:0]  sample_len;
  logic [3:0]  last_bit;

  assign sample_len = bus.long_sample ? adclp_pkg::SAMPLE_LONG
                                      : adclp_pkg::SAMPLE_SHORT;
  // Trials run MSB first; lower resolutions stop early
  always_comb begin
    unique case (bus.mode)
      adclp_pkg::MODE_8:  last_bit = 4'h4;
      adclp_pkg::MODE_10: last_bit = 4'h2;
      default:            last_bit = 4'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    done_reg <= 1'b0;
    if (!rstn) begin
      state_reg <= adclp_pkg::E_IDLE;
      cnt_reg   <= 6'h00;
      bit_reg   <= 4'hb;
      code_reg  <= 12'h000;
      res_reg   <= 12'h000;
    end else if (bus.start) begin
      state_reg <= adclp_pkg::E_SAMPLE;
      cnt_reg   <= 6'h00;
      code_reg  <= 12'h000;
    end else if (bus.abort) begin
      state_reg <= adclp_pkg::E_IDLE;
    end else if (bus.tick) begin
      unique case (state_reg)
        adclp_pkg::E_IDLE: ;
        adclp_pkg::E_SAMPLE: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == sample_len - 6'h01) begin
            state_reg <= adclp_pkg::E_SAR;
            bit_reg   <= 4'hb;
            code_reg  <= 12'h800;
          end
        end
        adclp_pkg::E_SAR: begin
          // Comparator high: input at or above trial, keep the bit
          code_reg[bit_reg] <= cmp_in;
          if (bit_reg == last_bit) begin
            state_reg <= adclp_pkg::E_IDLE;
            done_reg  <= 1'b1;
            res_reg   <= ((code_reg & ~(12'h001 << last_bit))
                         | ({11'h000, cmp_in} << last_bit)) >> last_bit;
          end else begin
            bit_reg <= bit_reg - 4'h1;
            code_reg[bit_reg - 4'h1] <= 1'b1;
          end
        end
      endcase
    end
  end

  assign bus.busy    = (state_reg != adclp_pkg::E_IDLE);
  assign bus.done    = done_reg;
  assign bus.result  = res_reg;
  assign dac_code    = code_reg;
  assign sample_hold = (state_reg == adclp_pkg::E_SAMPLE);
endmodule
`default_nettype wire

// ---- verification/adclp_analog_model.sv ----
`default_nettype none
module adclp_analog_model (
  input  wire logic [4:0]  mux_channel,
  input  wire logic [11:0] level,
  input  wire logic [11:0] dac_code,
  output logic             cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // One level shared by every channel, the sensor channel included
  // Comparator keeps the trial bit while the input is at or above it
  assign cmp_in = (level >= dac_code) && (mux_channel <= 5'h1f);
endmodule
`default_nettype wire

// ---- verification/adclp_ctrl_monitor.sv ----
`default_nettype none
module adclp_ctrl_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        hw_trigger,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        lp_stop_mode,
  input wire logic [11:0] dac_code,
  input wire logic        sample_hold,
  input wire logic [4:0]  mux_channel,
  input wire logic        temp_sensor_en,
  input wire logic        conv_irq
);
  // Shadow of the trigger select bit, as software last wrote it
  logic trig_sel_reg;
  always_ff @(posedge clk) begin
    if (!rstn || lp_stop_mode)
      trig_sel_reg <= 1'b0;
    else if (wr && addr == adclp_pkg::OFF_TRIG)
      trig_sel_reg <= wdata[adclp_pkg::TRG_SEL];
  end

  a_reset_values: assert property (@(posedge clk)
    !rstn |=> !conv_irq && rdata == 16'h0 && mux_channel == 5'h1f)
    else $error("outputs not at reset values");
  a_lp_disable: assert property (@(posedge clk) disable iff (!rstn)
    lp_stop_mode |=> !conv_irq && !sample_hold && dac_code == 12'h0
      && mux_channel == 5'h1f)
    else $error("low-power stop did not disable the block");
  a_temp_route: assert property (@(posedge clk) disable iff (!rstn)
    temp_sensor_en == (mux_channel == adclp_pkg::TEMP_CHANNEL))
    else $error("sensor enable does not follow channel");
  a_sw_start: assert property (@(posedge clk) disable iff (!rstn)
    wr && addr == adclp_pkg::OFF_CHAN && !trig_sel_reg && !wait_mode
      && !stop_mode && !lp_stop_mode |=> sample_hold)
    else $error("channel write did not start sampling");
  a_sw_blocked: assert property (@(posedge clk) disable iff (!rstn)
    (wait_mode || stop_mode) && wr && addr == adclp_pkg::OFF_CHAN
      && !hw_trigger |=> !sample_hold)
    else $error("software start accepted in wait or stop");
  a_chan_clears: assert property (@(posedge clk) disable iff (!rstn)
    wr && addr == adclp_pkg::OFF_CHAN |=> !conv_irq)
    else $error("channel write left the flag set");
  a_irq_holds: assert property (@(posedge clk) disable iff (!rstn)
    $fell(conv_irq) |-> $past(wr) || $past(rd) || $past(lp_stop_mode))
    else $error("interrupt dropped without cause");
  a_trial_start: assert property (@(posedge clk) disable iff (!rstn)
    $fell(sample_hold) && !$past(wr) && !$past(stop_mode)
      && !$past(lp_stop_mode) |-> dac_code == 12'h800)
    else $error("first trial not at midscale");
  a_stop_keeps: assert property (@(posedge clk) disable iff (!rstn)
    stop_mode && $past(stop_mode) && !$past(wr) && !$past(lp_stop_mode)
      |-> $stable(mux_channel))
    else $error("channel changed during stop");
  a_read_window: assert property (@(posedge clk) disable iff (!rstn)
    !rd |=> rdata == 16'h0)
    else $error("read data outside its cycle");
endmodule

bind adclp_ctrl adclp_ctrl_monitor u_mon (.clk(clk), .rstn(rstn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .hw_trigger(hw_trigger), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .lp_stop_mode(lp_stop_mode), .dac_code(dac_code),
  .sample_hold(sample_hold), .mux_channel(mux_channel),
  .temp_sensor_en(temp_sensor_en), .conv_irq(conv_irq));
`default_nettype wire

// ---- verification/adclp_ctrl_tb.sv ----
`default_nettype none
module adclp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        hw_trig = 1'b0, wait_m = 1'b0, stop_m = 1'b0;
  logic        lp_m = 1'b0, async_tick = 1'b0, hit;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata;
  logic [11:0] level = 12'h0, dac_code, lv;
  logic        cmp_in, sample_hold, temp_en, conv_irq;
  logic [4:0]  mux_ch, ch;
  logic [31:0] seed = 32'hf354;
  int          failures = 0, checks = 0, cyc = 0;

  adclp_ctrl DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .hw_trigger(hw_trig),
    .wait_mode(wait_m), .stop_mode(stop_m), .lp_stop_mode(lp_m),
    .alt_clock_tick(1'b0), .async_clock_tick(async_tick), .cmp_in(cmp_in),
    .dac_code(dac_code), .sample_hold(sample_hold), .mux_channel(mux_ch),
    .temp_sensor_en(temp_en), .conv_irq(conv_irq));
  adclp_analog_model u_analog (.mux_channel(mux_ch), .level(level),
    .dac_code(dac_code), .cmp_in(cmp_in));

  always #4 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Right-aligned result for the resolution code
  function automatic logic [15:0] res(input logic [11:0] l,
                                      input logic [1:0] m);
    if (m == 2'h0) return {8'h0, l[11:4]};
    if (m == 2'h2) return {6'h0, l[11:2]};
    return {4'h0, l};
  endfunction

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] v;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
    chk($sformatf("reg %h", a), v, e);
  endtask

  // Records whether the interrupt showed at any rising edge of the window
  task automatic wait_irq(input int n);
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (conv_irq === 1'b1) hit = 1'b1;
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    async_tick <= (cyc % 3 == 0);
    if (cyc == 6000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(4'h0, 16'h0000);
    rchk(4'h1, 16'h0000);
    rchk(4'h2, 16'h001f);
    rchk(4'h9, 16'h0000);
    wreg(4'h0, 16'h0098);
    rchk(4'h0, 16'h0098);
    wreg(4'h1, 16'h00ff);
    rchk(4'h1, 16'h007b);
    // Configure in the documented order: clocks, trigger, averaging
    wreg(4'h0, 16'h0000);
    wreg(4'h1, 16'h0000);
    wreg(4'h3, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      ch = (i == 0) ? 5'h1a : seed[4:0];
      lv = (i == 1) ? 12'hfff : seed[27:16];
      level <= lv;
      wreg(4'h2, {8'h0, 3'b010, ch});
      rchk(4'h1, 16'h0080);
      wait_irq(40);
      chk("irq", {15'h0, hit}, 16'h1);
      chk("mux", {11'h0, mux_ch}, {11'h0, ch});
      chk("temp", {15'h0, temp_en}, {15'h0, ch == 5'h1a});
      rchk(4'h6, res(lv, 2'h0));
      chk("irq clear", {15'h0, conv_irq}, 16'h0);
    end
    wreg(4'h0, 16'h0008);
    level <= 12'h9a7;
    wreg(4'h2, 16'h0045);
    wait_irq(40);
    rchk(4'h6, res(12'h9a7, 2'h2));
    wreg(4'h0, 16'h0000);
    wreg(4'h3, 16'h0004);
    level <= 12'h5c3;
    wreg(4'h2, 16'h0045);
    wait_irq(30);
    chk("avg early", {15'h0, hit}, 16'h0);
    wait_irq(80);
    chk("avg done", {15'h0, hit}, 16'h1);
    rchk(4'h6, res(12'h5c3, 2'h0));
    wreg(4'h3, 16'h0000);
    wreg(4'h4, 16'h0080);
    wreg(4'h1, 16'h0030);
    level <= 12'h100;
    wreg(4'h2, 16'h0045);
    wait_irq(40);
    chk("cmp false", {15'h0, hit}, 16'h0);
    level <= 12'hf00;
    wreg(4'h2, 16'h0045);
    wait_irq(40);
    chk("cmp true", {15'h0, hit}, 16'h1);
    rchk(4'h6, 16'h00f0);
    wreg(4'h1, 16'h0000);
    wreg(4'h0, 16'h0001);
    wreg(4'h2, 16'h0045);
    wait_m <= 1'b1;
    wait_irq(40);
    chk("wait run", {15'h0, hit}, 16'h1);
    wreg(4'h2, 16'h0045);
    wait_irq(40);
    chk("wait sw", {15'h0, hit}, 16'h0);
    wreg(4'h1, 16'h0040);
    hw_trig <= 1'b1;
    @(posedge clk);
    hw_trig <= 1'b0;
    wait_irq(40);
    chk("wait hw", {15'h0, hit}, 16'h1);
    wait_m <= 1'b0;
    wreg(4'h1, 16'h0000);
    level <= 12'h3c0;
    wreg(4'h2, 16'h0047);
    repeat (3) @(posedge clk);
    stop_m <= 1'b1;
    wait_irq(40);
    chk("stop abort", {15'h0, hit}, 16'h0);
    stop_m <= 1'b0;
    wait_irq(30);
    chk("no resume", {15'h0, hit}, 16'h0);
    rchk(4'h2, 16'h0047);
    rchk(4'h6, 16'h00f0);
    wreg(4'h0, 16'h0003);
    level <= 12'h6e1;
    wreg(4'h2, 16'h0045);
    stop_m <= 1'b1;
    wait_irq(200);
    chk("async stop", {15'h0, hit}, 16'h1);
    rchk(4'h6, res(12'h6e1, 2'h0));
    stop_m <= 1'b0;
    wreg(4'h0, 16'h0098);
    lp_m <= 1'b1;
    repeat (2) @(posedge clk);
    lp_m <= 1'b0;
    rchk(4'h0, 16'h0000);
    rchk(4'h2, 16'h001f);
    give_verdict();
  end
endmodule
`default_nettype wire
